// ### rtl/vcf_top.sv
// Purpose: Vibration comb filter, filtered output rate and tip alert pin
// Assumes: Samples, rate select, tip and fault come from logic on clk
// Notes:   Alert pin is two signals; pin level is resolved outside
// Summary of operation
// - Alert pin driven low when all normal
// - Tip-over event drives alert pin high
// - Sensor fault releases alert pin to high-Z
// - Samples pass a second-order comb filter
// - Response is squared normalized 512-sample sum
// - Six sample clocks, 100 kHz down by halves
// - Output rate is sample clock over 2048
// - Both axes under 0.375 g lock alert out
`timescale 1ns/1ps
`include "vcf_params.svh"

module vcf_top #(
  parameter int FS_DIV      = `VCF_FS_DIV_BASE, // Clocks per 100 kHz sample
  parameter int PWRON_CYC   = `VCF_PWRON_CYC    // Clocks of power-on wait
) (
  input  wire logic                 clk,          // 20 MHz system clock
  input  wire logic                 rst_n,        // Synchronous reset, active low
  input  wire logic [2:0]           rate_sel,     // Sample clock step, 0 fastest
  input  wire vcf_pkg::vcf_sample_t sample_x,     // Raw X sample
  input  wire vcf_pkg::vcf_sample_t sample_y,     // Raw Y sample
  input  wire logic                 tip_detect,   // Angle logic reports tip-over
  input  wire logic                 sensor_fault, // Self-test reports a fault
  output vcf_pkg::vcf_sample_t      filt_x,       // Filtered X result
  output vcf_pkg::vcf_sample_t      filt_y,       // Filtered Y result
  output logic                      filt_valid,   // Pulse on new result
  output logic                      fs_tick,      // Filter sample clock enable
  output logic                      low_g_lock,   // Low-g lockout active
  output logic                      bus_ready,    // Power-on wait elapsed
  output logic                      alert_o,      // Alert pin output value
  output logic                      alert_oe      // Alert pin output enable
);

  logic [2:0]                 rate_eff;
  logic [12:0]                div_cnt;
  logic [12:0]                div_last;
  logic [10:0]                samp_cnt;
  logic                       dump_en;
  logic                       out_load;
  logic [19:0]                pwr_cnt;
  logic                       tip_live;
  vcf_pkg::vcf_alert_e        alert_state;
  vcf_pkg::vcf_alert_e        next_alert;
  vcf_pkg::vcf_sample_t       axis_in  [2];
  vcf_pkg::vcf_sample_t       axis_out [2];

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Magnitude below the lockout level
  function automatic logic below_lowg(input vcf_pkg::vcf_sample_t v);
    below_lowg = (v < `VCF_LOWG_LSB) && (v > -`VCF_LOWG_LSB);
  endfunction

  // ****************************************************************
  // Filter sample clock divider
  // ****************************************************************
  // Unused codes fall to the slowest clock
  assign rate_eff = (rate_sel > `VCF_RATE_SLOWEST) ? `VCF_RATE_SLOWEST : rate_sel;
  assign div_last = 13'((FS_DIV << rate_eff) - 1);

  // Period doubles with each rate step
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_cnt <= '0;
    end else if (div_cnt >= div_last) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 13'h1;
    end
  end

  assign fs_tick = rst_n && (div_cnt >= div_last);

  // ****************************************************************
  // Sample and decimation counter
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      samp_cnt <= '0;
    end else if (fs_tick) begin
      samp_cnt <= samp_cnt + 11'h1;
    end
  end

  // Dump every 512 samples, publish every 2048
  assign dump_en  = fs_tick && (samp_cnt[8:0] == `VCF_SUM_LAST);
  assign out_load = fs_tick && (samp_cnt == `VCF_DECIM_FIRST);

  // ****************************************************************
  // Per-axis comb filters
  // ****************************************************************
  assign axis_in[0] = sample_x;
  assign axis_in[1] = sample_y;

  generate
    for (genvar g = 0; g < 2; g++) begin : g_axis
      vcf_cic2 u_cic (
        .clk     (clk),
        .rst_n   (rst_n),
        .smp_en  (fs_tick),
        .dump_en (dump_en),
        .din     (axis_in[g]),
        .dout    (axis_out[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Filtered result hold
  // ****************************************************************
  // Results stand until the next one replaces them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      filt_x     <= '0;
      filt_y     <= '0;
      filt_valid <= 1'b0;
    end else begin
      filt_valid <= out_load;
      if (out_load) begin
        filt_x <= axis_out[0];
        filt_y <= axis_out[1];
      end
    end
  end

  // ****************************************************************
  // Power-on wait
  // ****************************************************************
  // Tells bus logic when the host may first talk
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwr_cnt   <= '0;
      bus_ready <= 1'b0;
    end else if (pwr_cnt >= 20'(PWRON_CYC - 1)) begin
      bus_ready <= 1'b1;
    end else begin
      pwr_cnt <= pwr_cnt + 20'h1;
    end
  end

  // ****************************************************************
  // Low-g lockout and alert pin
  // ****************************************************************
  // Lock out on the filtered values of both axes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      low_g_lock <= 1'b0;
    end else begin
      low_g_lock <= below_lowg(filt_x) && below_lowg(filt_y);
    end
  end

  assign tip_live = tip_detect && !low_g_lock;

  // Fault outranks tip, tip outranks normal
  always_comb begin
    if (sensor_fault) begin
      next_alert = vcf_pkg::VCF_ALERT_FAULT;
    end else if (tip_live) begin
      next_alert = vcf_pkg::VCF_ALERT_TIP;
    end else begin
      next_alert = vcf_pkg::VCF_ALERT_NORMAL;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alert_state <= vcf_pkg::VCF_ALERT_NORMAL;
    end else begin
      alert_state <= next_alert;
    end
  end

  // Pin drive from the state flop
  always_comb begin
    case (alert_state)
      vcf_pkg::VCF_ALERT_TIP: begin
        alert_o  = 1'b1;
        alert_oe = 1'b1;
      end
      vcf_pkg::VCF_ALERT_FAULT: begin
        alert_o  = 1'b0;
        alert_oe = 1'b0;
      end
      default: begin
        alert_o  = 1'b0;
        alert_oe = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_last_of_block;
    fs_tick && (samp_cnt == `VCF_DECIM_LAST);
  endsequence

  sequence s_publish;
    out_load ##1 filt_valid;
  endsequence

  AST_ALERT_LOW: assert property (
    (!sensor_fault && !tip_live) |=> (alert_oe && !alert_o))
    else $error("alert pin not driven low in normal operation");

  AST_ALERT_HIGH: assert property (
    (!sensor_fault && tip_live) |=> (alert_oe && alert_o))
    else $error("alert pin not driven high on tip-over");

  AST_ALERT_Z: assert property (sensor_fault |=> !alert_oe)
    else $error("alert pin still driven during fault");

  AST_FS_SPACING: assert property (fs_tick |=> !fs_tick [*8])
    else $error("sample clock enable too dense");

  AST_FS_PERIOD: assert property (
    (fs_tick && $stable(rate_eff)) |-> ($past(div_cnt) == div_last - 13'h1))
    else $error("sample clock period does not match selection");

  AST_OUT_RATE: assert property (s_last_of_block |=> (samp_cnt == `VCF_DECIM_FIRST))
    else $error("output rate broken");

  AST_PUBLISH_NEXT: assert property (out_load |-> s_publish)
    else $error("new result not flagged after publish tick");

  AST_PUBLISH: assert property (filt_valid |-> $past(out_load) && (samp_cnt == 11'h1))
    else $error("result published off the 2048 boundary");

  AST_LOCKOUT: assert property ((low_g_lock && !sensor_fault) |=> !alert_o)
    else $error("alert raised under low-g lockout");

  AST_HOLD: assert property (!out_load |=> ($stable(filt_x) && $stable(filt_y)))
    else $error("filtered result changed between updates");

endmodule

// ### rtl/vcf_params.svh
// Purpose: Shared constants of the vibration comb filter and tip alert
// Assumes: 20 MHz system clock, 14-bit two's complement samples at 1024 LSB/g
// Notes:   Counts derive from times and rates by expression
`ifndef VCF_PARAMS_SVH
`define VCF_PARAMS_SVH

// ****************************************************************
// Clock and filter sample clock
// ****************************************************************
`define VCF_CLK_HZ       20000000
`define VCF_FS_MAX_HZ    100000
`define VCF_FS_DIV_BASE  (`VCF_CLK_HZ / `VCF_FS_MAX_HZ)
`define VCF_RATE_SLOWEST 3'h5

// ****************************************************************
// Comb filter shape and decimation
// ****************************************************************
`define VCF_SUM_LAST     9'h1FF
`define VCF_DECIM_LAST   11'h7FF
`define VCF_DECIM_FIRST  11'h000
`define VCF_NORM_LSB     18

// ****************************************************************
// Low-g lockout and power-on wait
// ****************************************************************
`define VCF_LOWG_LSB     14'sh180
`define VCF_PWRON_MS     30
`define VCF_PWRON_CYC    ((`VCF_CLK_HZ / 1000) * `VCF_PWRON_MS)

`endif

// ### rtl/vcf_pkg.sv
// Purpose: Types of the vibration comb filter and tip alert
// Assumes: Constants come from vcf_params.svh
// Notes:   Nothing here is imported; use vcf_pkg::name
package vcf_pkg;

  // Alert pin states
  typedef enum logic [1:0] {
    VCF_ALERT_NORMAL,
    VCF_ALERT_TIP,
    VCF_ALERT_FAULT
  } vcf_alert_e;

  typedef logic signed [13:0] vcf_sample_t;
  typedef logic signed [31:0] vcf_acc_t;

endpackage

// ### rtl/vcf_cic2.sv
// Purpose: Second-order integrate and dump running-sum filter for one axis
// Assumes: dump_en only ever coincides with smp_en, once per 512 samples
// Notes:   Output is the squared 512-sum response scaled down by 512 squared
`timescale 1ns/1ps
`include "vcf_params.svh"

module vcf_cic2 (
  input  wire logic                 clk,     // System clock
  input  wire logic                 rst_n,   // Synchronous reset, active low
  input  wire logic                 smp_en,  // Filter sample clock enable
  input  wire logic                 dump_en, // Last sample of a 512 block
  input  wire vcf_pkg::vcf_sample_t din,     // Raw sample
  output vcf_pkg::vcf_sample_t      dout     // Normalized filter result
);

  vcf_pkg::vcf_acc_t din_ext;
  vcf_pkg::vcf_acc_t integ1;
  vcf_pkg::vcf_acc_t integ2;
  vcf_pkg::vcf_acc_t prev2;
  vcf_pkg::vcf_acc_t prev1;
  vcf_pkg::vcf_acc_t comb1;
  vcf_pkg::vcf_acc_t comb2;
  vcf_pkg::vcf_acc_t next_comb1;

  // ****************************************************************
  // Integrators at the sample rate
  // ****************************************************************
  assign din_ext = {{18{din[13]}}, din};

  // Two cascaded accumulators, wrap is harmless
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      integ1 <= '0;
      integ2 <= '0;
    end else if (smp_en) begin
      integ1 <= integ1 + din_ext;
      integ2 <= integ2 + integ1;
    end
  end

  // ****************************************************************
  // Differencers at the dump rate
  // ****************************************************************
  assign next_comb1 = integ2 - prev2;

  // Two cascaded differences give the squared running sum
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prev2 <= '0;
      prev1 <= '0;
      comb1 <= '0;
      comb2 <= '0;
    end else if (dump_en) begin
      prev2 <= integ2;
      comb1 <= next_comb1;
      prev1 <= next_comb1;
      comb2 <= next_comb1 - prev1;
    end
  end

  // Divide by 512 squared
  assign dout = comb2[31:`VCF_NORM_LSB];

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_INTEG_ADD: assert property (@(posedge clk) disable iff (!rst_n)
    smp_en |=> integ1 == $past(integ1) + $past(din_ext))
    else $error("integrator did not take the sample");

  AST_COMB_DIFF: assert property (@(posedge clk) disable iff (!rst_n)
    dump_en |=> (comb1 == $past(integ2) - $past(prev2)) && (prev2 == $past(integ2)))
    else $error("differencer result wrong at dump");

endmodule

// ### bench/vcf_host_model.sv
// Purpose: Host model, rate select over the bus and alert pin watch
// Assumes: Alert pin has no pull resistor, so a released pin floats
// Notes:   Level 0 low, 1 high, 2 released, 3 unknown
`timescale 1ns/1ps
module vcf_host_model (
  input  wire logic       bus_ready, // Power-on wait elapsed
  input  wire logic [2:0] rate_req,  // Rate the bench asks for
  input  wire logic       alert_o,   // Pin value from device
  input  wire logic       alert_oe,  // Pin enable from device
  output logic [2:0]      rate_sel,  // Rate written over the bus
  output logic [1:0]      alert_lvl  // Level seen on the pin
);
  wire alert_pin;
  // Pin resolution, floats when released
  assign alert_pin = alert_oe ? alert_o : 1'bz;
  // No bus write before the power-on wait ends
  assign rate_sel = bus_ready ? rate_req : 3'h0;
  // Pin level decode
  always_comb begin
    if (alert_pin === 1'bz) alert_lvl = 2'h2;
    else if (alert_pin === 1'b1) alert_lvl = 2'h1;
    else if (alert_pin === 1'b0) alert_lvl = 2'h0;
    else alert_lvl = 2'h3;
  end
endmodule

// ### bench/vcf_top_tb.sv
// Purpose: Self-checking bench of the comb filter and tip alert
// Assumes: Constant samples, so a settled result equals the sample
// Notes:   Short counts: FS_DIV 10, PWRON_CYC 20
`timescale 1ns/1ps
module vcf_top_tb;
  localparam int FS_DIV = 10;
  logic                 clk, rst_n, tip_detect, sensor_fault;
  logic [2:0]           rate_req, rate_sel;
  vcf_pkg::vcf_sample_t sample_x, sample_y, filt_x, filt_y, hold_x, hold_y;
  logic                 filt_valid, fs_tick, low_g_lock, bus_ready, alert_o, alert_oe;
  logic [1:0]           alert_lvl;
  logic                 lock_m, lock_nx, lock_pend, run;
  int                   error_cnt, compares, cyc, pub_cnt, seed, c, n;
  int                   qx[$], qy[$];
  time                  last_t;

  vcf_top #(.FS_DIV(FS_DIV), .PWRON_CYC(20)) i_dut (.clk(clk), .rst_n(rst_n),
    .rate_sel(rate_sel), .sample_x(sample_x), .sample_y(sample_y), .tip_detect(tip_detect),
    .sensor_fault(sensor_fault), .filt_x(filt_x), .filt_y(filt_y), .filt_valid(filt_valid),
    .fs_tick(fs_tick), .low_g_lock(low_g_lock), .bus_ready(bus_ready), .alert_o(alert_o),
    .alert_oe(alert_oe));
  vcf_host_model i_host (.bus_ready(bus_ready), .rate_req(rate_req), .alert_o(alert_o),
    .alert_oe(alert_oe), .rate_sel(rate_sel), .alert_lvl(alert_lvl));

  // Clock
  always #25 clk = ~clk;

  task automatic chk_val(input vcf_pkg::vcf_sample_t got, input int e);
    compares++;
    if (got !== vcf_pkg::vcf_sample_t'(e)) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, vcf_pkg::vcf_sample_t'(e));
    end
  endtask

  task automatic chk_lvl(input logic [1:0] got, input logic [1:0] e);
    compares++;
    if (got !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, e);
    end
  endtask

  task automatic chk_cnt(input int got, input int e);
    compares++;
    if (got != e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h exp %h", $time, got, e);
    end
  endtask

  task automatic final_report;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Drive tip and fault, look at the pin one cycle later
  task automatic alert_step(input logic t, input logic f, input logic [1:0] e);
    tip_detect = t;
    sensor_fault = f;
    @(negedge clk);
    chk_lvl(alert_lvl, e);
  endtask

  // Cycles up to the next filter sample tick
  task automatic wait_tick(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (fs_tick !== 1'b1 && k < 2000);
  endtask

  // Reset seen released at a rising edge, avoids a race at release
  always @(posedge clk) run <= rst_n;

  // Hang guard, tests take about 43200 cycles
  always @(negedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      final_report;
    end
  end

  // Reference model: results, hold, spacing and lockout
  always @(negedge clk) begin
    if (run) begin
      if (lock_pend) lock_m = lock_nx;
      lock_pend = 0;
      chk_lvl({1'b0, low_g_lock}, {1'b0, lock_m});
      if (filt_valid === 1'b1) begin
        chk_val(filt_x, qx[0]);
        chk_val(filt_y, qy[0]);
        lock_nx = qx[0] < 384 && qx[0] > -384 && qy[0] < 384 && qy[0] > -384;
        lock_pend = 1;
        if (pub_cnt > 0) chk_cnt(int'(($time - last_t) / 50), 2048 * FS_DIV);
        if (qx.size() > 1) void'(qx.pop_front());
        if (qy.size() > 1) void'(qy.pop_front());
        last_t = $time;
        pub_cnt++;
      end else begin
        chk_val(filt_x, hold_x);
        chk_val(filt_y, hold_y);
      end
    end
    hold_x = filt_x;
    hold_y = filt_y;
  end

  // Main sequence
  initial begin
    seed = 32'h6F68;
    clk = 0; rst_n = 0; tip_detect = 0; sensor_fault = 0; rate_req = 3'h0;
    lock_m = 1; // Zero results after reset sit under the lockout level
    lock_pend = 0;
    c = 384 + ($unsigned($random(seed)) % 1500);
    if ($random(seed) & 1) c = -c;
    sample_x = vcf_pkg::vcf_sample_t'(c);
    qx = {0, c};
    c = $random(seed) % 384;
    sample_y = vcf_pkg::vcf_sample_t'(c);
    qy = {0, c};
    repeat (10) @(negedge clk);
    rst_n = 1;
    chk_lvl(alert_lvl, 2'h0);
    repeat (19) @(negedge clk);
    chk_lvl({1'b0, bus_ready}, 2'h0);
    repeat (2) @(negedge clk);
    chk_lvl({1'b0, bus_ready}, 2'h1);
    $display("test power-on wait done");
    alert_step(1'b1, 1'b0, 2'h0);
    alert_step(1'b1, 1'b1, 2'h2);
    alert_step(1'b0, 1'b0, 2'h0);
    $display("test lockout after zero result done");
    while (pub_cnt < 2) @(negedge clk);
    repeat (2) @(negedge clk);
    alert_step(1'b1, 1'b0, 2'h1);
    alert_step(1'b1, 1'b1, 2'h2);
    alert_step(1'b1, 1'b0, 2'h1);
    alert_step(1'b0, 1'b0, 2'h0);
    $display("test alert levels done");
    c = $random(seed) % 384;
    sample_x = vcf_pkg::vcf_sample_t'(c);
    qx = {c};
    c = $random(seed) % 384;
    sample_y = vcf_pkg::vcf_sample_t'(c);
    qy = {c};
    while (pub_cnt < 3) @(negedge clk);
    repeat (2) @(negedge clk);
    alert_step(1'b1, 1'b0, 2'h0);
    alert_step(1'b0, 1'b0, 2'h0);
    $display("test small result lockout done");
    for (int r = 0; r < 8; r++) begin
      rate_req = r[2:0];
      wait_tick(n);
      wait_tick(n);
      chk_cnt(n, FS_DIV << ((r > 5) ? 5 : r));
    end
    $display("test sample clock steps done");
    final_report;
  end
endmodule
